// file: hdl/core_regs_pkg.sv
package core_regs_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ACC_W = 40;
  localparam int unsigned GUARD_W = 8;
  localparam int unsigned NUM_AR = 8;
  localparam int unsigned NUM_IRQ = 16;

  // register window in data space
  localparam logic [15:0] MMR_LIMIT = 16'h0020;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h00;
  localparam logic [4:0] OFS_IRQ_FLAG = 5'h01;
  localparam logic [4:0] OFS_FLAG_ST = 5'h06;
  localparam logic [4:0] OFS_MODE_ST = 5'h07;
  localparam logic [4:0] OFS_ACC_A_LOW = 5'h08;
  localparam logic [4:0] OFS_ACC_A_HIGH = 5'h09;
  localparam logic [4:0] OFS_ACC_A_GUARD = 5'h0a;
  localparam logic [4:0] OFS_ACC_B_LOW = 5'h0b;
  localparam logic [4:0] OFS_ACC_B_HIGH = 5'h0c;
  localparam logic [4:0] OFS_ACC_B_GUARD = 5'h0d;
  localparam logic [4:0] OFS_TEMP = 5'h0e;
  localparam logic [4:0] OFS_TRANS = 5'h0f;
  localparam logic [4:0] OFS_AR0 = 5'h10;
  localparam logic [4:0] OFS_STACK = 5'h18;
  localparam logic [4:0] OFS_CIRC = 5'h19;
  localparam logic [4:0] OFS_RPT_CNT = 5'h1a;
  localparam logic [4:0] OFS_RPT_START = 5'h1b;
  localparam logic [4:0] OFS_RPT_END = 5'h1c;
  localparam logic [4:0] OFS_MEM_CFG = 5'h1d;

  // flag status word fields
  localparam int unsigned FS_DP_LSB = 0;
  localparam int unsigned FS_DP_W = 9;
  localparam int unsigned FS_OVB_BIT = 9;
  localparam int unsigned FS_OVA_BIT = 10;
  localparam int unsigned FS_C_BIT = 11;
  localparam int unsigned FS_TC_BIT = 12;
  localparam int unsigned FS_ARP_LSB = 13;

  // values after reset
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [39:0] RST_ACC = 40'h00_0000_0000;
  localparam logic [15:0] RST_STACK = 16'h0000;

  // extra cost of a long-offset or absolute single-operand access
  localparam logic [1:0] LONG_ADDR_EXTRA = 2'h1;

  function automatic logic [1:0] access_extra(input logic long_addr, input logic single_op);
    access_extra = (long_addr && single_op) ? LONG_ADDR_EXTRA : 2'h0;
  endfunction
endpackage

// file: hdl/dsp_core_register_set.sv
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
// Contract
// - stack pointer is 16 bits, points at last push
// - push predecrements, pop postincrements all 16 bits
// - all stack users go through stack pointer
// - two independent 40-bit accumulators A and B
// - each accumulator mapped as low, high, guard
// - eight 16-bit address registers, readable and updatable
// - temp register gives multiplicand and shift count
// - temp register gives dynamic bit position
// - exponent writes temp; normalize reads it
// - dual add/sub take branch metric from temp
// - compare-select shifts decision into transition register
// - circular size register gives block length
// - repeat counter holds block repeat count
// - repeat start and end addresses held
// - mask register masks each interrupt individually
// - flag register shows pending state of interrupts
// - flag word holds flags and pointers; mode word
// - memory config register selects memory layout
// - long-offset single-operand access costs one extra
// - registers mapped at lowest data addresses
module dsp_core_register_set #(
  parameter int unsigned NUM_AR_P = core_regs_pkg::NUM_AR
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // data-space register port
  input wire logic [15:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // stack requests from call, return, trap, interrupt and push/pop ops
  input wire logic STK_PUSH,
  input wire logic STK_POP,
  // accumulator results
  input wire logic ACC_A_WE,
  input wire logic [39:0] ACC_A_VAL,
  input wire logic ACC_B_WE,
  input wire logic [39:0] ACC_B_VAL,
  // address register updates, one slot per register
  input wire logic [NUM_AR_P-1:0] AR_UPD_EN,
  input wire logic [NUM_AR_P*16-1:0] AR_UPD_VAL,
  // temp operand loads and exponent result
  input wire logic TEMP_WE,
  input wire logic [15:0] TEMP_VAL,
  input wire logic EXP_WE,
  input wire logic [15:0] EXP_VAL,
  // compare-select-store, selects accumulator B when high
  input wire logic VITERBI_COMPARE_SELECT_OP_EN,
  input wire logic VITERBI_COMPARE_SELECT_OP_SEL_B,
  // arithmetic flags
  input wire logic FLAG_WE,
  input wire logic OVA_IN,
  input wire logic OVB_IN,
  input wire logic CARRY_IN,
  input wire logic TEST_IN,
  // repeat counter step and interrupt events
  input wire logic RPT_DEC,
  input wire logic [15:0] IRQ_SET,
  input wire logic [15:0] IRQ_ACK,
  // operand addressing kind of the current access
  input wire logic OP_LONG_ADDR,
  input wire logic OP_SINGLE,
  // register contents
  output logic [39:0] ACC_A,
  output logic [39:0] ACC_B,
  output logic [NUM_AR_P*16-1:0] AR_OUT,
  output logic [15:0] TEMP_OUT,
  output logic [5:0] SHIFT_COUNT,
  output logic [3:0] BIT_POS,
  output logic [15:0] TRANS_OUT,
  output logic [15:0] STACK_PTR,
  output logic [15:0] CIRC_SIZE,
  output logic [15:0] RPT_COUNT,
  output logic [15:0] RPT_START,
  output logic [15:0] RPT_END,
  output logic [15:0] FLAG_STATUS,
  output logic [15:0] MODE_STATUS,
  output logic [15:0] MEM_CFG,
  output logic [15:0] IRQ_MASK,
  output logic [15:0] IRQ_FLAGS,
  output logic [15:0] IRQ_PENDING,
  output logic [1:0] EXTRA_CYCLES
);
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;
  logic [39:0] acc_a_r, acc_a_nxt;
  logic [39:0] acc_b_r, acc_b_nxt;
  logic [15:0] ar_r [NUM_AR_P];
  logic [15:0] ar_nxt [NUM_AR_P];
  logic [15:0] temp_r, temp_nxt;
  logic [15:0] trans_r, trans_nxt;
  logic [15:0] sp_r, sp_nxt;
  logic [15:0] circ_r, circ_nxt;
  logic [15:0] rcnt_r, rcnt_nxt;
  logic [15:0] rsta_r, rsta_nxt;
  logic [15:0] rend_r, rend_nxt;
  logic [15:0] fst_r, fst_nxt;
  logic [15:0] mst_r, mst_nxt;
  logic [15:0] mcfg_r, mcfg_nxt;
  logic [15:0] imask_r, imask_nxt;
  logic [15:0] iflag_r, iflag_nxt;
  logic [15:0] pend_r, pend_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [1:0] extra_r, extra_nxt;
  logic in_window;
  logic [4:0] ofs;
  logic wr_hit;
  logic [15:0] sel_hi;
  logic [15:0] sel_lo;
  logic cmp_decision;
  // registers live only in the lowest data addresses
  assign in_window = (ADDR < core_regs_pkg::MMR_LIMIT);
  assign ofs = ADDR[4:0];
  assign wr_hit = WR && in_window;
  function automatic logic hit(input logic [4:0] o);
    hit = wr_hit && (ofs == o);
  endfunction
  // signed compare of high word against low word of the chosen accumulator
  assign sel_hi = VITERBI_COMPARE_SELECT_OP_SEL_B ? acc_b_r[31:16] : acc_a_r[31:16];
  assign sel_lo = VITERBI_COMPARE_SELECT_OP_SEL_B ? acc_b_r[15:0] : acc_a_r[15:0];
  assign cmp_decision = ($signed(sel_hi) > $signed(sel_lo));
  always_comb begin
    acc_a_nxt = acc_a_r;
    acc_b_nxt = acc_b_r;
    temp_nxt = temp_r;
    trans_nxt = trans_r;
    sp_nxt = sp_r;
    circ_nxt = circ_r;
    rcnt_nxt = rcnt_r;
    rsta_nxt = rsta_r;
    rend_nxt = rend_r;
    fst_nxt = fst_r;
    mst_nxt = mst_r;
    mcfg_nxt = mcfg_r;
    imask_nxt = imask_r;
    for (int i = 0; i < NUM_AR_P; i++) begin
      ar_nxt[i] = ar_r[i];
    end
    // side effects first, explicit writes below override them
    if (ACC_A_WE) begin
      acc_a_nxt = ACC_A_VAL;
    end
    if (ACC_B_WE) begin
      acc_b_nxt = ACC_B_VAL;
    end
    for (int i = 0; i < NUM_AR_P; i++) begin
      if (AR_UPD_EN[i]) begin
        ar_nxt[i] = AR_UPD_VAL[i*16 +: 16];
      end
    end
    if (TEMP_WE) begin
      temp_nxt = TEMP_VAL;
    end
    if (EXP_WE) begin
      temp_nxt = EXP_VAL;
    end
    if (VITERBI_COMPARE_SELECT_OP_EN) begin
      trans_nxt = {trans_r[14:0], cmp_decision};
      fst_nxt[core_regs_pkg::FS_TC_BIT] = cmp_decision;
    end
    if (FLAG_WE) begin
      fst_nxt[core_regs_pkg::FS_OVA_BIT] = OVA_IN;
      fst_nxt[core_regs_pkg::FS_OVB_BIT] = OVB_IN;
      fst_nxt[core_regs_pkg::FS_C_BIT] = CARRY_IN;
      fst_nxt[core_regs_pkg::FS_TC_BIT] = TEST_IN;
    end
    // push and pop both asserted cancel out; the wrap is silent
    if (STK_PUSH && !STK_POP) begin
      sp_nxt = sp_r - 16'h0001;
    end else if (STK_POP && !STK_PUSH) begin
      sp_nxt = sp_r + 16'h0001;
    end
    if (RPT_DEC) begin
      rcnt_nxt = rcnt_r - 16'h0001;
    end
    // explicit writes win
    if (hit(core_regs_pkg::OFS_ACC_A_LOW)) begin
      acc_a_nxt[15:0] = WDATA;
    end
    if (hit(core_regs_pkg::OFS_ACC_A_HIGH)) begin
      acc_a_nxt[31:16] = WDATA;
    end
    if (hit(core_regs_pkg::OFS_ACC_A_GUARD)) begin
      acc_a_nxt[39:32] = WDATA[7:0];
    end
    if (hit(core_regs_pkg::OFS_ACC_B_LOW)) begin
      acc_b_nxt[15:0] = WDATA;
    end
    if (hit(core_regs_pkg::OFS_ACC_B_HIGH)) begin
      acc_b_nxt[31:16] = WDATA;
    end
    if (hit(core_regs_pkg::OFS_ACC_B_GUARD)) begin
      acc_b_nxt[39:32] = WDATA[7:0];
    end
    for (int i = 0; i < NUM_AR_P; i++) begin
      if (hit(core_regs_pkg::OFS_AR0 + 5'(i))) begin
        ar_nxt[i] = WDATA;
      end
    end
    if (hit(core_regs_pkg::OFS_TEMP)) begin
      temp_nxt = WDATA;
    end
    if (hit(core_regs_pkg::OFS_TRANS)) begin
      trans_nxt = WDATA;
    end
    if (hit(core_regs_pkg::OFS_STACK)) begin
      sp_nxt = WDATA;
    end
    if (hit(core_regs_pkg::OFS_CIRC)) begin
      circ_nxt = WDATA;
    end
    if (hit(core_regs_pkg::OFS_RPT_CNT)) begin
      rcnt_nxt = WDATA;
    end
    if (hit(core_regs_pkg::OFS_RPT_START)) begin
      rsta_nxt = WDATA;
    end
    if (hit(core_regs_pkg::OFS_RPT_END)) begin
      rend_nxt = WDATA;
    end
    if (hit(core_regs_pkg::OFS_FLAG_ST)) begin
      fst_nxt = WDATA;
    end
    if (hit(core_regs_pkg::OFS_MODE_ST)) begin
      mst_nxt = WDATA;
    end
    if (hit(core_regs_pkg::OFS_MEM_CFG)) begin
      mcfg_nxt = WDATA;
    end
    if (hit(core_regs_pkg::OFS_IRQ_MASK)) begin
      imask_nxt = WDATA;
    end
  end
  // interrupt flags: write-one-to-clear, a new event beats any clear
  always_comb begin
    logic [15:0] clr;
    clr = IRQ_ACK;
    if (hit(core_regs_pkg::OFS_IRQ_FLAG)) begin
      clr = clr | WDATA;
    end
    iflag_nxt = (iflag_r & ~clr) | IRQ_SET;
    pend_nxt = iflag_nxt & imask_nxt;
    extra_nxt = core_regs_pkg::access_extra(OP_LONG_ADDR, OP_SINGLE);
  end
  // read data appear the cycle after the strobe, zero when unmapped
  always_comb begin
    rdata_nxt = 16'h0000;
    if (RD && in_window) begin
      case (ofs)
        core_regs_pkg::OFS_IRQ_MASK: rdata_nxt = imask_r;
        core_regs_pkg::OFS_IRQ_FLAG: rdata_nxt = iflag_r;
        core_regs_pkg::OFS_FLAG_ST: rdata_nxt = fst_r;
        core_regs_pkg::OFS_MODE_ST: rdata_nxt = mst_r;
        core_regs_pkg::OFS_ACC_A_LOW: rdata_nxt = acc_a_r[15:0];
        core_regs_pkg::OFS_ACC_A_HIGH: rdata_nxt = acc_a_r[31:16];
        core_regs_pkg::OFS_ACC_A_GUARD: rdata_nxt = {8'h00, acc_a_r[39:32]};
        core_regs_pkg::OFS_ACC_B_LOW: rdata_nxt = acc_b_r[15:0];
        core_regs_pkg::OFS_ACC_B_HIGH: rdata_nxt = acc_b_r[31:16];
        core_regs_pkg::OFS_ACC_B_GUARD: rdata_nxt = {8'h00, acc_b_r[39:32]};
        core_regs_pkg::OFS_TEMP: rdata_nxt = temp_r;
        core_regs_pkg::OFS_TRANS: rdata_nxt = trans_r;
        core_regs_pkg::OFS_STACK: rdata_nxt = sp_r;
        core_regs_pkg::OFS_CIRC: rdata_nxt = circ_r;
        core_regs_pkg::OFS_RPT_CNT: rdata_nxt = rcnt_r;
        core_regs_pkg::OFS_RPT_START: rdata_nxt = rsta_r;
        core_regs_pkg::OFS_RPT_END: rdata_nxt = rend_r;
        core_regs_pkg::OFS_MEM_CFG: rdata_nxt = mcfg_r;
        default: begin
          if (ofs >= core_regs_pkg::OFS_AR0 && ofs < core_regs_pkg::OFS_AR0 + 5'(NUM_AR_P)) begin
            rdata_nxt = ar_r[3'(ofs - core_regs_pkg::OFS_AR0)];
          end
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      acc_a_r <= core_regs_pkg::RST_ACC;
      acc_b_r <= core_regs_pkg::RST_ACC;
      for (int i = 0; i < NUM_AR_P; i++) begin
        ar_r[i] <= core_regs_pkg::RST_WORD;
      end
      temp_r <= core_regs_pkg::RST_WORD;
      trans_r <= core_regs_pkg::RST_WORD;
      sp_r <= core_regs_pkg::RST_STACK;
      circ_r <= core_regs_pkg::RST_WORD;
      rcnt_r <= core_regs_pkg::RST_WORD;
      rsta_r <= core_regs_pkg::RST_WORD;
      rend_r <= core_regs_pkg::RST_WORD;
      fst_r <= core_regs_pkg::RST_WORD;
      mst_r <= core_regs_pkg::RST_WORD;
      mcfg_r <= core_regs_pkg::RST_WORD;
      imask_r <= core_regs_pkg::RST_WORD;
      iflag_r <= core_regs_pkg::RST_WORD;
      pend_r <= core_regs_pkg::RST_WORD;
      rdata_r <= core_regs_pkg::RST_WORD;
      extra_r <= 2'h0;
    end else begin
      acc_a_r <= acc_a_nxt;
      acc_b_r <= acc_b_nxt;
      for (int i = 0; i < NUM_AR_P; i++) begin
        ar_r[i] <= ar_nxt[i];
      end
      temp_r <= temp_nxt;
      trans_r <= trans_nxt;
      sp_r <= sp_nxt;
      circ_r <= circ_nxt;
      rcnt_r <= rcnt_nxt;
      rsta_r <= rsta_nxt;
      rend_r <= rend_nxt;
      fst_r <= fst_nxt;
      mst_r <= mst_nxt;
      mcfg_r <= mcfg_nxt;
      imask_r <= imask_nxt;
      iflag_r <= iflag_nxt;
      pend_r <= pend_nxt;
      rdata_r <= rdata_nxt;
      extra_r <= extra_nxt;
    end
  end

  // outputs are the flops themselves
  assign RDATA = rdata_r;
  assign ACC_A = acc_a_r;
  assign ACC_B = acc_b_r;
  always_comb begin
    for (int i = 0; i < NUM_AR_P; i++) begin
      AR_OUT[i*16 +: 16] = ar_r[i];
    end
  end
  // temp feeds multiplier, dual add/sub metric, shifter and bit test
  assign TEMP_OUT = temp_r;
  assign SHIFT_COUNT = temp_r[5:0];
  assign BIT_POS = temp_r[3:0];
  assign TRANS_OUT = trans_r;
  assign STACK_PTR = sp_r;
  assign CIRC_SIZE = circ_r;
  assign RPT_COUNT = rcnt_r;
  assign RPT_START = rsta_r;
  assign RPT_END = rend_r;
  assign FLAG_STATUS = fst_r;
  assign MODE_STATUS = mst_r;
  assign MEM_CFG = mcfg_r;
  assign IRQ_MASK = imask_r;
  assign IRQ_FLAGS = iflag_r;
  assign IRQ_PENDING = pend_r;
  assign EXTRA_CYCLES = extra_r;

endmodule

// file: verification/core_exec_model.sv
`timescale 1ns/10ps
module core_exec_model (
  // control from the bench
  input wire logic clk,
  input wire logic go,
  input wire logic slow,
  input wire logic [3:0] n_push,
  input wire logic [3:0] n_pop,
  // stack requests toward the register set
  output logic push = 1'b0,
  output logic pop = 1'b0,
  output logic busy
);
  logic [3:0] np = 4'h0;
  logic [3:0] nq = 4'h0;
  logic gap = 1'b0;
  assign busy = (np != 4'h0) || (nq != 4'h0);
  // pushes first, then pops, like a call followed by its return
  always @(posedge clk) begin
    push <= 1'b0;
    pop <= 1'b0;
    gap <= slow & ~gap;
    if (go) begin
      np <= n_push;
      nq <= n_pop;
    end else if (!gap && np != 4'h0) begin
      push <= 1'b1;
      np <= np - 4'h1;
    end else if (!gap && nq != 4'h0) begin
      pop <= 1'b1;
      nq <= nq - 4'h1;
    end
  end
endmodule

// file: verification/dsp_core_register_set_properties.sv
`timescale 1ns/10ps
module dsp_core_register_set_properties (
  // clock, reset and register port
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [15:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  // side-effect inputs
  input wire logic STK_PUSH,
  input wire logic STK_POP,
  input wire logic EXP_WE,
  input wire logic [15:0] EXP_VAL,
  input wire logic VITERBI_COMPARE_SELECT_OP_EN,
  input wire logic OP_LONG_ADDR,
  input wire logic OP_SINGLE,
  input wire logic [15:0] IRQ_SET,
  // register contents
  input wire logic [15:0] TEMP_OUT,
  input wire logic [5:0] SHIFT_COUNT,
  input wire logic [15:0] TRANS_OUT,
  input wire logic [15:0] STACK_PTR,
  input wire logic [15:0] IRQ_MASK,
  input wire logic [15:0] IRQ_FLAGS,
  input wire logic [15:0] IRQ_PENDING,
  input wire logic [1:0] EXTRA_CYCLES
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // an explicit write in the same cycle overrides the side effect, so exclude it
  wire sp_wr = WR && (ADDR == 16'h0018);
  property p_push;
    STK_PUSH && !STK_POP && !sp_wr |=> STACK_PTR == $past(STACK_PTR) - 16'h0001;
  endproperty
  a_push: assert property (p_push) else $error("push did not predecrement");
  property p_pop;
    STK_POP && !STK_PUSH && !sp_wr |=> STACK_PTR == $past(STACK_PTR) + 16'h0001;
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not postincrement");
  property p_sp_wr;
    sp_wr |=> STACK_PTR == $past(WDATA);
  endproperty
  a_sp_wr: assert property (p_sp_wr) else $error("stack write lost");
  property p_sp_rd;
    RD && ADDR == 16'h0018 |=> RDATA == $past(STACK_PTR);
  endproperty
  a_sp_rd: assert property (p_sp_rd) else $error("stack read wrong");
  property p_unmapped;
    RD && ADDR >= 16'h0020 |=> RDATA == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_extra;
    1'b1 |=> EXTRA_CYCLES == {1'b0, $past(OP_LONG_ADDR) & $past(OP_SINGLE)};
  endproperty
  a_extra: assert property (p_extra) else $error("extra cycle wrong");
  property p_pending;
    IRQ_PENDING == (IRQ_FLAGS & IRQ_MASK);
  endproperty
  a_pending: assert property (p_pending) else $error("pending not masked");
  property p_irq_set;
    IRQ_SET != 16'h0000 |=> (IRQ_FLAGS & $past(IRQ_SET)) == $past(IRQ_SET);
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("flag not set");
  property p_viterbi_compare_select_op;
    VITERBI_COMPARE_SELECT_OP_EN && !(WR && ADDR == 16'h000f) |=> (TRANS_OUT & 16'hfffe) == ($past(TRANS_OUT) << 1);
  endproperty
  a_viterbi_compare_select_op: assert property (p_viterbi_compare_select_op) else $error("transition not shifted");
  property p_exp;
    EXP_WE && !(WR && ADDR == 16'h000e) |=> TEMP_OUT == $past(EXP_VAL);
  endproperty
  a_exp: assert property (p_exp) else $error("exponent not stored");
  property p_shift;
    WR && ADDR == 16'h000e |=> SHIFT_COUNT == $past(WDATA[5:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("shift count wrong");
endmodule
bind dsp_core_register_set dsp_core_register_set_properties u_props (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .STK_PUSH(STK_PUSH), .STK_POP(STK_POP), .EXP_WE(EXP_WE), .EXP_VAL(EXP_VAL),
  .VITERBI_COMPARE_SELECT_OP_EN(VITERBI_COMPARE_SELECT_OP_EN), .OP_LONG_ADDR(OP_LONG_ADDR), .OP_SINGLE(OP_SINGLE), .IRQ_SET(IRQ_SET),
  .TEMP_OUT(TEMP_OUT), .SHIFT_COUNT(SHIFT_COUNT), .TRANS_OUT(TRANS_OUT),
  .STACK_PTR(STACK_PTR), .IRQ_MASK(IRQ_MASK), .IRQ_FLAGS(IRQ_FLAGS),
  .IRQ_PENDING(IRQ_PENDING), .EXTRA_CYCLES(EXTRA_CYCLES));

// file: verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, temp_val = 16'h0000, exp_val = 16'h0000;
  logic [15:0] irq_set = 16'h0000, irq_ack = 16'h0000;
  logic wr = 1'b0, rd = 1'b0, a_we = 1'b0, b_we = 1'b0, temp_we = 1'b0, exp_we = 1'b0;
  logic viterbi_compare_select_op_en = 1'b0, sel_b = 1'b0, flag_we = 1'b0, ova = 1'b0, ovb = 1'b0, cy = 1'b0;
  logic tst = 1'b0, rpt_dec = 1'b0, op_long = 1'b0, op_single = 1'b0, go = 1'b0, slow = 1'b0;
  logic [39:0] acc_val = 40'h00_0000_0000;
  logic [7:0] ar_en = 8'h00;
  logic [127:0] ar_val = 128'h0;
  logic [3:0] n_push = 4'h0, n_pop = 4'h0;
  wire push, pop, busy;
  wire [39:0] acc_a, acc_b;
  wire [127:0] ar_out;
  wire [15:0] rdata, temp_out, trans, sp, circ, rcnt, rsta, rend, fst, mst, mcfg, imask, iflg, ipnd;
  wire [5:0] shc;
  wire [3:0] bpos;
  wire [1:0] extra;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  dsp_core_register_set u_dut (
    .CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .STK_PUSH(push), .STK_POP(pop), .ACC_A_WE(a_we), .ACC_A_VAL(acc_val), .ACC_B_WE(b_we),
    .ACC_B_VAL(acc_val), .AR_UPD_EN(ar_en), .AR_UPD_VAL(ar_val), .TEMP_WE(temp_we),
    .TEMP_VAL(temp_val), .EXP_WE(exp_we), .EXP_VAL(exp_val), .VITERBI_COMPARE_SELECT_OP_EN(viterbi_compare_select_op_en),
    .VITERBI_COMPARE_SELECT_OP_SEL_B(sel_b), .FLAG_WE(flag_we), .OVA_IN(ova), .OVB_IN(ovb), .CARRY_IN(cy),
    .TEST_IN(tst), .RPT_DEC(rpt_dec), .IRQ_SET(irq_set), .IRQ_ACK(irq_ack),
    .OP_LONG_ADDR(op_long), .OP_SINGLE(op_single), .ACC_A(acc_a), .ACC_B(acc_b),
    .AR_OUT(ar_out), .TEMP_OUT(temp_out), .SHIFT_COUNT(shc), .BIT_POS(bpos), .TRANS_OUT(trans),
    .STACK_PTR(sp), .CIRC_SIZE(circ), .RPT_COUNT(rcnt), .RPT_START(rsta), .RPT_END(rend),
    .FLAG_STATUS(fst), .MODE_STATUS(mst), .MEM_CFG(mcfg), .IRQ_MASK(imask), .IRQ_FLAGS(iflg),
    .IRQ_PENDING(ipnd), .EXTRA_CYCLES(extra));
  core_exec_model u_exec (.clk(clk), .go(go), .slow(slow), .n_push(n_push), .n_pop(n_pop),
    .push(push), .pop(pop), .busy(busy));
  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // whole run needs under two hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors = errors + 1;
      results();
    end
  end
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] e, input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask
  task automatic t_map;
    for (int i = 0; i < 32; i++) rdc(i[15:0], 16'h0000, "reset");
    wrr(16'h0020, 16'h1234);
    rdc(16'h0020, 16'h0000, "unmapped");
    wrr(16'h0003, 16'hffff);
    rdc(16'h0003, 16'h0000, "unused");
    $display("test map done");
  endtask
  task automatic t_stack;
    int k;
    wrr(16'h0018, 16'h0001);
    chk("sp_wr", 16'h0001, sp);
    for (int r = 0; r < 2; r++) begin
      @(posedge clk);
      n_push <= r ? 4'h2 : 4'h3;
      n_pop <= r ? 4'h0 : 4'h1;
      slow <= !r;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      #1;
      k = 0;
      while (busy === 1'b1 && k < 40) begin
        @(posedge clk);
        #1;
        k++;
      end
      @(posedge clk);
      #1;
      chk("sp", r ? 16'hfffd : 16'hffff, sp);
    end
    rdc(16'h0018, 16'hfffd, "sp_rd");
    $display("test stack done");
  endtask
  task automatic t_acc;
    wrr(16'h0008, 16'h1111);
    wrr(16'h0009, 16'h2222);
    wrr(16'h000a, 16'hff33);
    chk("acc_a", 40'h33_2222_1111, acc_a);
    rdc(16'h000a, 16'h0033, "a_guard");
    @(posedge clk);
    acc_val <= 40'h99_8888_7777;
    b_we <= 1'b1;
    @(posedge clk);
    b_we <= 1'b0;
    #1;
    chk("acc_b", 40'h99_8888_7777, acc_b);
    chk("acc_a_kept", 40'h33_2222_1111, acc_a);
    rdc(16'h000b, 16'h7777, "b_low");
    rdc(16'h000c, 16'h8888, "b_high");
    rdc(16'h000d, 16'h0099, "b_guard");
    // a load keeps high above low so the compare-select test still sees a win
    @(posedge clk);
    acc_val <= 40'h12_7654_3210;
    a_we <= 1'b1;
    @(posedge clk);
    a_we <= 1'b0;
    #1;
    chk("acc_a_ld", 40'h12_7654_3210, acc_a);
    chk("acc_b_kept", 40'h99_8888_7777, acc_b);
    $display("test acc done");
  endtask
  task automatic t_ar_temp;
    @(posedge clk);
    ar_en <= 8'h81;
    ar_val <= {16'hbeef, 96'h0, 16'h1234};
    temp_we <= 1'b1;
    temp_val <= 16'h012b;
    exp_we <= 1'b1;
    exp_val <= 16'h0007;
    @(posedge clk);
    ar_en <= 8'h00;
    exp_we <= 1'b0;
    #1;
    chk("ar0_ld", 16'h1234, ar_out[15:0]);
    chk("ar7_ld", 16'hbeef, ar_out[127:112]);
    chk("exp", 16'h0007, temp_out);
    @(posedge clk);
    temp_we <= 1'b0;
    #1;
    chk("temp", 16'h012b, temp_out);
    chk("shift", 6'h2b, shc);
    chk("bitpos", 4'hb, bpos);
    wrr(16'h000e, 16'h00a7);
    chk("temp_wr", 16'h00a7, temp_out);
    chk("shift_wr", 6'h27, shc);
    rdc(16'h0010, 16'h1234, "ar0");
    wrr(16'h0013, 16'h5555);
    chk("ar3", 16'h5555, ar_out[63:48]);
    $display("test ar temp done");
  endtask
  task automatic t_viterbi_compare_select_op;
    // a high beats low; b high is negative, so signed compare loses
    @(posedge clk);
    viterbi_compare_select_op_en <= 1'b1;
    @(posedge clk);
    sel_b <= 1'b1;
    @(posedge clk);
    viterbi_compare_select_op_en <= 1'b0;
    #1;
    chk("trans", 16'h0002, trans);
    chk("tc", 1'b0, fst[12]);
    @(posedge clk);
    addr <= 16'h000f;
    wdata <= 16'habcd;
    wr <= 1'b1;
    viterbi_compare_select_op_en <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    viterbi_compare_select_op_en <= 1'b0;
    #1;
    chk("trans_wr", 16'habcd, trans);
    $display("test viterbi_compare_select_op done");
  endtask
  task automatic t_misc;
    @(posedge clk);
    flag_we <= 1'b1;
    ova <= 1'b1;
    ovb <= 1'b1;
    cy <= 1'b1;
    tst <= 1'b1;
    @(posedge clk);
    flag_we <= 1'b0;
    #1;
    chk("flags", 16'h1e00, fst);
    wrr(16'h0006, 16'h6005);
    wrr(16'h0007, 16'h0a5a);
    wrr(16'h001d, 16'h00c3);
    wrr(16'h0019, 16'h0040);
    wrr(16'h001b, 16'h2000);
    wrr(16'h001c, 16'h20ff);
    chk("flag_wr", 16'h6005, fst);
    chk("mode", 16'h0a5a, mst);
    chk("memcfg", 16'h00c3, mcfg);
    chk("circ", 16'h0040, circ);
    chk("rpt_start", 16'h2000, rsta);
    chk("rpt_end_out", 16'h20ff, rend);
    rdc(16'h001c, 16'h20ff, "rpt_end");
    @(posedge clk);
    rpt_dec <= 1'b1;
    @(posedge clk);
    addr <= 16'h001a;
    wdata <= 16'h0010;
    wr <= 1'b1;
    #1;
    chk("rpt_wrap", 16'hffff, rcnt);
    @(posedge clk);
    wr <= 1'b0;
    rpt_dec <= 1'b0;
    #1;
    chk("rpt_wr", 16'h0010, rcnt);
    $display("test misc done");
  endtask
  task automatic t_irq;
    wrr(16'h0000, 16'h0005);
    @(posedge clk);
    irq_set <= 16'h0007;
    @(posedge clk);
    irq_set <= 16'h0000;
    #1;
    chk("irq_mask", 16'h0005, imask);
    chk("irq_flags", 16'h0007, iflg);
    chk("irq_pend", 16'h0005, ipnd);
    wrr(16'h0001, 16'h0001);
    chk("irq_w1c", 16'h0006, iflg);
    @(posedge clk);
    irq_ack <= 16'h000a;
    irq_set <= 16'h0008;
    @(posedge clk);
    irq_ack <= 16'h0000;
    irq_set <= 16'h0000;
    #1;
    chk("irq_ack", 16'h000c, iflg);
    chk("irq_pend2", 16'h0004, ipnd);
    $display("test irq done");
  endtask
  task automatic t_extra;
    @(posedge clk);
    op_long <= 1'b1;
    op_single <= 1'b1;
    @(posedge clk);
    op_single <= 1'b0;
    #1;
    chk("extra", 2'h1, extra);
    @(posedge clk);
    op_long <= 1'b0;
    #1;
    chk("no_extra", 2'h0, extra);
    $display("test extra done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_map();
    t_stack();
    t_acc();
    t_ar_temp();
    t_viterbi_compare_select_op();
    t_misc();
    t_irq();
    t_extra();
    results();
  end
endmodule
